// ===== hw/sfbl_loader.sv
`timescale 1ns/100ps
// How it works
// - hold next-image start address from header
// - start address returns to default at power-up
// - only address bits 23..12 settable, low zero
// - chain head loads; slave-strapped devices stay idle
// - forward-wake set relays image data downstream
// - select low 100..200 ns after ready rises
// - first clock edge 2.8..4.4 us after ready
// - serial clock phases at least 7.5 ns
// - power cycle, or a restart pulse once the first load has run, starts load
// - loading barred while restart pin is GPIO
// - first load after power-up reads address zero
// - quick-read strap picks 0x03 or 0x0b command
// - restart pulse after the first load jumps to header address
module sfbl_loader #(
    parameter int HALF_CYC = 1
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        ready_pin,
    input  wire logic        restart_n_pin,
    input  wire logic        quick_read_select_n,
    input  wire logic        master_serial_flash_mode,
    input  wire logic        restart_is_gpio,
    input  wire logic        forward_wake,
    input  wire logic        header_jump_valid,
    input  wire logic [11:0] header_jump_addr,
    input  wire logic        load_done,
    input  wire logic        flash_miso,
    output logic             flash_select_n,
    output logic             flash_sck,
    output logic             flash_mosi,
    output logic [7:0]       image_byte,
    output logic             image_byte_valid,
    output logic             chain_data,
    output logic             chain_clk,
    output logic             load_active
);

    localparam int WAIT_CLK = sfbl_pkg::EDGE_MIN_CYC - sfbl_pkg::SYNC_LAT_CYC - HALF_CYC;
    localparam logic [7:0] WAIT_LOAD = 8'(WAIT_CLK - 1);

    if (HALF_CYC < sfbl_pkg::SCK_PHASE_MIN_CYC
        || 2 * HALF_CYC < sfbl_pkg::SCK_PERIOD_MIN_CYC) begin : g_bad_sck
        $error("sfbl_loader: serial clock half period too short");
    end
    if (WAIT_CLK < 1 || WAIT_CLK > 255
        || sfbl_pkg::SYNC_LAT_CYC + WAIT_CLK + HALF_CYC + 1 > sfbl_pkg::EDGE_MAX_CYC)
    begin : g_bad_wait
        $error("sfbl_loader: first clock edge cannot meet its window");
    end
    if (sfbl_pkg::SYNC_LAT_CYC < sfbl_pkg::SEL_MIN_CYC
        || sfbl_pkg::SYNC_LAT_CYC + 1 > sfbl_pkg::SEL_MAX_CYC) begin : g_bad_sel
        $error("sfbl_loader: select timing cannot meet its window");
    end

    typedef struct packed {
        sfbl_pkg::sfbl_st_t st;
        logic [7:0]         wait_cnt;
        logic [4:0]         bit_cnt;
        logic [31:0]        sh_out;
        logic [7:0]         sh_in;
        logic               fast;
        logic               master;
        logic [11:0]        jump_hi;
        logic               first_done;
        logic               rdy_d;
        logic               rst_d;
        logic               sel_n;
        logic               mosi;
        logic [7:0]         byte_o;
        logic               byte_vld;
        logic               fwd_d;
        logic               fwd_clk;
        logic               run;
        logic               busy;
    } sfbl_state_t;

    sfbl_state_t s;
    sfbl_state_t n;

    logic [3:0]  syn;
    logic        sck_w;
    logic        rise_p;
    logic        fall_p;
    logic        rdy_rise;
    logic        rst_end;
    logic        start_p;
    logic        fast_now;
    logic [7:0]  cmd;
    logic [23:0] addr;

    sfbl_sync #(
        .W   (sfbl_pkg::SYN_W),
        .RST (sfbl_pkg::SYN_RESET)
    ) u_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .pin_in  ({master_serial_flash_mode, quick_read_select_n,
                   restart_n_pin, ready_pin}),
        .level_r (syn)
    );

    sfbl_sck_div #(
        .HALF_CYC (HALF_CYC)
    ) u_div (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .run     (s.run & ~load_done & ~restart_is_gpio),
        .sck_r   (sck_w),
        .rise_p  (rise_p),
        .fall_p  (fall_p)
    );

    always_comb begin
        n          = s;
        n.rdy_d    = syn[sfbl_pkg::SYN_READY];
        n.rst_d    = syn[sfbl_pkg::SYN_RESTART];
        n.byte_vld = 1'b0;
        rdy_rise   = syn[sfbl_pkg::SYN_READY] & ~s.rdy_d;
        rst_end    = syn[sfbl_pkg::SYN_RESTART] & ~s.rst_d & s.first_done
                     & syn[sfbl_pkg::SYN_READY];
        fast_now   = rdy_rise ? ~syn[sfbl_pkg::SYN_QUICK] : s.fast;
        if (rdy_rise) begin
            n.fast   = ~syn[sfbl_pkg::SYN_QUICK];
            n.master = syn[sfbl_pkg::SYN_MODE];
        end
        cmd = fast_now ? sfbl_pkg::CMD_FAST_READ : sfbl_pkg::CMD_READ;
        addr = s.first_done ? {s.jump_hi, sfbl_pkg::ADDR_LOW_ZERO}
                            : sfbl_pkg::POWERUP_ADDR;
        start_p = ~restart_is_gpio & (rdy_rise ? syn[sfbl_pkg::SYN_MODE]
                                               : (rst_end & s.master));
        if (header_jump_valid && s.st == sfbl_pkg::ST_DATA) begin
            n.jump_hi = header_jump_addr;
        end
        case (s.st)
            sfbl_pkg::ST_IDLE: begin
                n.run = 1'b0;
            end
            sfbl_pkg::ST_SEL: begin
                if (s.wait_cnt == 8'h00) begin
                    n.st  = sfbl_pkg::ST_SHIFT;
                    n.run = 1'b1;
                end else begin
                    n.wait_cnt = s.wait_cnt - 8'h01;
                end
            end
            sfbl_pkg::ST_SHIFT: begin
                if (fall_p) begin
                    if (s.bit_cnt == sfbl_pkg::SHIFT_LAST) begin
                        n.bit_cnt = '0;
                        n.mosi    = 1'b0;
                        n.st      = s.fast ? sfbl_pkg::ST_DUMMY : sfbl_pkg::ST_DATA;
                    end else begin
                        n.sh_out  = {s.sh_out[30:0], 1'b0};
                        n.mosi    = s.sh_out[30];
                        n.bit_cnt = s.bit_cnt + 5'h01;
                    end
                end
            end
            sfbl_pkg::ST_DUMMY: begin
                if (fall_p) begin
                    if (s.bit_cnt == sfbl_pkg::DUMMY_LAST) begin
                        n.bit_cnt = '0;
                        n.st      = sfbl_pkg::ST_DATA;
                    end else begin
                        n.bit_cnt = s.bit_cnt + 5'h01;
                    end
                end
            end
            sfbl_pkg::ST_DATA: begin
                if (rise_p) begin
                    n.sh_in = {s.sh_in[6:0], flash_miso};
                    if (s.bit_cnt == sfbl_pkg::BYTE_LAST) begin
                        n.bit_cnt  = '0;
                        n.byte_o   = {s.sh_in[6:0], flash_miso};
                        n.byte_vld = 1'b1;
                    end else begin
                        n.bit_cnt = s.bit_cnt + 5'h01;
                    end
                end
            end
            default: begin
                n.st = sfbl_pkg::ST_IDLE;
            end
        endcase
        if (s.st == sfbl_pkg::ST_DATA && forward_wake) begin
            if (rise_p) begin
                n.fwd_d   = flash_miso;
                n.fwd_clk = 1'b1;
            end else if (fall_p) begin
                n.fwd_clk = 1'b0;
            end
        end else begin
            n.fwd_clk = 1'b0;
        end
        // done or gpio ends the frame; a restart in the same cycle wins over done, never over gpio
        if (load_done || restart_is_gpio) begin
            n.st    = sfbl_pkg::ST_IDLE;
            n.sel_n = 1'b1;
            n.run   = 1'b0;
            n.mosi  = 1'b0;
        end
        if (start_p) begin
            n.st         = sfbl_pkg::ST_SEL;
            n.sel_n      = 1'b0;
            n.run        = 1'b0;
            n.wait_cnt   = WAIT_LOAD;
            n.sh_out     = {cmd, addr};
            n.mosi       = cmd[7];
            n.bit_cnt    = '0;
            n.first_done = 1'b1;
        end
        n.busy = (n.st != sfbl_pkg::ST_IDLE);
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s         <= '0;
            s.st      <= sfbl_pkg::ST_IDLE;
            s.jump_hi <= sfbl_pkg::JUMP_RESET;
            s.rst_d   <= 1'b1;
            s.fast    <= 1'b0;
            s.sel_n   <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign flash_select_n   = s.sel_n;
    assign flash_sck        = sck_w;
    assign flash_mosi       = s.mosi;
    assign image_byte       = s.byte_o;
    assign image_byte_valid = s.byte_vld;
    assign chain_data       = s.fwd_d;
    assign chain_clk        = s.fwd_clk;
    assign load_active      = s.busy;

    // helper: cycles the serial clock has held its level
    logic [7:0] sck_hold_r;
    logic       sck_prev_r;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_hold_r <= 8'h00;
            sck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_w;
            if (sck_w != sck_prev_r) begin
                sck_hold_r <= 8'h01;
            end else if (sck_hold_r != 8'hff) begin
                sck_hold_r <= sck_hold_r + 8'h01;
            end
        end
    end

    localparam int A_RISE = 1 + WAIT_CLK + HALF_CYC;
    localparam int A_HALF = HALF_CYC;

    property p_sel_cause;
        @(posedge sys_clk) disable iff (!reset_n)
        $fell(flash_select_n) |-> $past(start_p);
    endproperty
    a_sel_cause: assert property (p_sel_cause) else $error("select fell without start");

    property p_first_edge;
        @(posedge sys_clk) disable iff (!reset_n || load_done || restart_is_gpio)
        start_p |-> ##A_RISE $rose(flash_sck);
    endproperty
    a_first_edge: assert property (p_first_edge) else $error("first clock edge mistimed");

    property p_sck_phase;
        @(posedge sys_clk) disable iff (!reset_n)
        (flash_sck != sck_prev_r) && s.run |-> $past(sck_hold_r) >= 8'(A_HALF);
    endproperty
    a_sck_phase: assert property (p_sck_phase) else $error("serial clock phase too short");

    property p_cmd;
        @(posedge sys_clk) disable iff (!reset_n)
        s.st == sfbl_pkg::ST_SEL && $past(start_p)
        |-> s.sh_out[31:24] == (s.fast ? sfbl_pkg::CMD_FAST_READ : sfbl_pkg::CMD_READ);
    endproperty
    a_cmd: assert property (p_cmd) else $error("read command does not match strap");

    property p_addr_low;
        @(posedge sys_clk) disable iff (!reset_n)
        s.st == sfbl_pkg::ST_SEL |-> s.sh_out[11:0] == sfbl_pkg::ADDR_LOW_ZERO;
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("address low bits not zero");

    property p_powerup_zero;
        @(posedge sys_clk) disable iff (!reset_n)
        $past(start_p) && !$past(s.first_done) |-> s.sh_out[23:0] == sfbl_pkg::POWERUP_ADDR;
    endproperty
    a_powerup_zero: assert property (p_powerup_zero) else $error("first load not zero");

    property p_jump;
        @(posedge sys_clk) disable iff (!reset_n)
        $past(start_p) && $past(s.first_done) |-> s.sh_out[23:12] == $past(s.jump_hi);
    endproperty
    a_jump: assert property (p_jump) else $error("reload ignored jump address");

    property p_jump_reset;
        @(posedge sys_clk) disable iff (!reset_n)
        !s.first_done |-> s.jump_hi == sfbl_pkg::JUMP_RESET;
    endproperty
    a_jump_reset: assert property (p_jump_reset) else $error("jump address not default");

    property p_gpio;
        @(posedge sys_clk) disable iff (!reset_n)
        restart_is_gpio |=> flash_select_n && !load_active;
    endproperty
    a_gpio: assert property (p_gpio) else $error("load ran while restart is gpio");

    property p_slave;
        @(posedge sys_clk) disable iff (!reset_n)
        rdy_rise && !syn[sfbl_pkg::SYN_MODE] && !load_active |=> !load_active;
    endproperty
    a_slave: assert property (p_slave) else $error("slave-strapped device started");

    property p_fwd;
        @(posedge sys_clk) disable iff (!reset_n || restart_is_gpio)
        forward_wake && s.st == sfbl_pkg::ST_DATA && rise_p
        |=> chain_data == $past(flash_miso) && chain_clk;
    endproperty
    a_fwd: assert property (p_fwd) else $error("data not forwarded");

    property p_frame;
        @(posedge sys_clk) disable iff (!reset_n)
        flash_select_n |-> !flash_sck;
    endproperty
    a_frame: assert property (p_frame) else $error("clock ran outside select");

endmodule : sfbl_loader

// ===== inc/sfbl_pkg.sv
package sfbl_pkg;

    // all times in picoseconds so that half-nanosecond figures stay exact
    localparam int CLK_PERIOD_PS      = 40000;
    localparam int SEL_MIN_PS         = 100000;
    localparam int SEL_MAX_PS         = 200000;
    localparam int EDGE_MIN_PS        = 2800000;
    localparam int EDGE_MAX_PS        = 4400000;
    localparam int SCK_PERIOD_MIN_PS  = 15000;
    localparam int SCK_PHASE_MIN_PS   = 7500;

    localparam int SEL_MIN_CYC = (SEL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SEL_MAX_CYC = SEL_MAX_PS / CLK_PERIOD_PS;
    localparam int EDGE_MIN_CYC = (EDGE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int EDGE_MAX_CYC = EDGE_MAX_PS / CLK_PERIOD_PS;
    localparam int SCK_PERIOD_MIN_CYC =
        (SCK_PERIOD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SCK_PHASE_MIN_CYC =
        (SCK_PHASE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // pin edge to synchroniser output, in sys_clk edges
    localparam int SYNC_LAT_CYC = 4;

    localparam int SYN_W       = 4;
    localparam int SYN_READY   = 0;
    localparam int SYN_RESTART = 1;
    localparam int SYN_QUICK   = 2;
    localparam int SYN_MODE    = 3;
    localparam logic [3:0] SYN_RESET = 4'h6;

    localparam logic [7:0] CMD_READ      = 8'h03;
    localparam logic [7:0] CMD_FAST_READ = 8'h0b;

    localparam int ADDR_W      = 24;
    localparam int ADDR_KEEP   = 12;
    localparam int JUMP_W      = ADDR_W - ADDR_KEEP;
    localparam logic [11:0] JUMP_RESET   = 12'h000;
    localparam logic [11:0] ADDR_LOW_ZERO = 12'h000;
    localparam logic [23:0] POWERUP_ADDR = 24'h000000;

    localparam int WAIT_W = 8;
    localparam int BIT_W  = 5;
    localparam logic [4:0] SHIFT_LAST = 5'h1f;
    localparam logic [4:0] DUMMY_LAST = 5'h07;
    localparam logic [4:0] BYTE_LAST  = 5'h07;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SEL   = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DUMMY = 3'b011,
        ST_DATA  = 3'b100
    } sfbl_st_t;

endpackage : sfbl_pkg

// ===== hw/sfbl_sync.sv
`timescale 1ns/100ps
module sfbl_sync #(
    parameter int           W   = 4,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_r
);

    typedef struct packed {
        logic [W-1:0] f1;
        logic [W-1:0] f2;
        logic [W-1:0] f3;
        logic [W-1:0] q;
    } sfbl_sync_st_t;

    sfbl_sync_st_t s;
    sfbl_sync_st_t n;

    if (W < 1) begin : g_bad_w
        $error("sfbl_sync: width must be at least one");
    end

    // a bit only moves once the second and third stage agree
    always_comb begin
        n    = s;
        n.f1 = pin_in;
        n.f2 = s.f1;
        n.f3 = s.f2;
        n.q  = (s.f2 & s.f3) | (s.q & (s.f2 ^ s.f3));
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= {RST, RST, RST, RST};
        end else begin
            s <= n;
        end
    end

    assign level_r = s.q;

endmodule : sfbl_sync

// ===== hw/sfbl_sck_div.sv
`timescale 1ns/100ps
module sfbl_sck_div #(
    parameter int HALF_CYC = 1
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic run,
    output logic      sck_r,
    output logic      rise_p,
    output logic      fall_p
);

    localparam int CW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          sck;
    } sfbl_div_st_t;

    sfbl_div_st_t s;
    sfbl_div_st_t n;

    if (HALF_CYC < 1) begin : g_bad_half
        $error("sfbl_sck_div: half period must be at least one cycle");
    end

    // the clock parks low, so the first edge after run is always a rise
    // fixed phase length
    always_comb begin
        n = s;
        if (!run) begin
            n.cnt = '0;
            n.sck = 1'b0;
        end else if (s.cnt == LAST) begin
            n.cnt = '0;
            n.sck = ~s.sck;
        end else begin
            n.cnt = s.cnt + CW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign sck_r  = s.sck;
    assign rise_p = run & (s.cnt == LAST) & ~s.sck;
    assign fall_p = run & (s.cnt == LAST) & s.sck;

endmodule : sfbl_sck_div

// ===== dv/sfbl_flash_model.sv
`timescale 1ns/100ps
module sfbl_flash_model (
    input  wire logic        flash_select_n,
    input  wire logic        flash_sck,
    input  wire logic        flash_mosi,
    output logic             flash_miso,
    output logic [7:0]       cmd_seen,
    output logic [23:0]      addr_seen,
    output int               data_rises
);
    logic [31:0] hdr_r;
    logic [7:0]  cur_byte;
    int          rises;
    int          hdr_len;

    function automatic logic [7:0] byte_at(input logic [23:0] a);
        return a[7:0] ^ a[19:12] ^ 8'h5a;
    endfunction : byte_at

    initial begin
        flash_miso = 1'b0;
        cmd_seen = 8'h00;
        addr_seen = 24'h000000;
        hdr_r = 32'h00000000;
        rises = 0;
        data_rises = 0;
        hdr_len = 32;
    end

    // line has no pull: once released it must not keep the last bit
    always @(posedge flash_select_n) begin
        flash_miso = ~flash_miso;
    end

    // sole image source for the device
    always @(negedge flash_select_n) begin
        rises = 0;
        data_rises = 0;
    end

    always @(posedge flash_sck) if (!flash_select_n) begin
        if (rises < 32) hdr_r = {hdr_r[30:0], flash_mosi};
        rises++;
        if (rises == 32) begin
            cmd_seen = hdr_r[31:24];
            addr_seen = hdr_r[23:0];
        end
        hdr_len = (cmd_seen == 8'h0b) ? 40 : 32;
        if (rises > hdr_len) data_rises++;
    end

    // data launched on the fall so it is settled at the next rise
    always @(negedge flash_sck) if (!flash_select_n && rises >= 32 && rises >= hdr_len) begin
        cur_byte = byte_at(addr_seen + 24'((rises - hdr_len) / 8));
        flash_miso = cur_byte[7 - ((rises - hdr_len) % 8)];
    end
endmodule : sfbl_flash_model

// ===== dv/sfbl_loader_tb_top.sv
`timescale 1ns/100ps
module sfbl_loader_tb_top;
    logic        sys_clk;
    logic        reset_n;
    logic        ready_pin;
    logic        restart_n_pin;
    logic        quick_read_select_n;
    logic        master_serial_flash_mode;
    logic        restart_is_gpio;
    logic        forward_wake;
    logic        header_jump_valid;
    logic [11:0] header_jump_addr;
    logic        load_done;
    logic        flash_miso;
    logic        flash_select_n;
    logic        flash_sck;
    logic        flash_mosi;
    logic [7:0]  image_byte;
    logic        image_byte_valid;
    logic        chain_data;
    logic        chain_clk;
    logic        load_active;
    logic [7:0]  cmd_seen;
    logic [23:0] addr_seen;
    int          data_rises;
    int          errors;
    int          checked;
    int          sel_falls;
    int          chain_cnt;
    realtime     t0;
    realtime     t_sel;
    realtime     t_sck;
    realtime     t_edge;
    realtime     min_phase;

    sfbl_loader i_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .ready_pin(ready_pin),
        .restart_n_pin(restart_n_pin), .quick_read_select_n(quick_read_select_n),
        .master_serial_flash_mode(master_serial_flash_mode),
        .restart_is_gpio(restart_is_gpio), .forward_wake(forward_wake),
        .header_jump_valid(header_jump_valid), .header_jump_addr(header_jump_addr),
        .load_done(load_done), .flash_miso(flash_miso), .flash_select_n(flash_select_n),
        .flash_sck(flash_sck), .flash_mosi(flash_mosi), .image_byte(image_byte),
        .image_byte_valid(image_byte_valid), .chain_data(chain_data),
        .chain_clk(chain_clk), .load_active(load_active)
    );

    sfbl_flash_model i_flash (
        .flash_select_n(flash_select_n), .flash_sck(flash_sck), .flash_mosi(flash_mosi),
        .flash_miso(flash_miso), .cmd_seen(cmd_seen), .addr_seen(addr_seen),
        .data_rises(data_rises)
    );

    always #20 sys_clk = ~sys_clk;

    always @(negedge flash_select_n) begin
        sel_falls++;
        chain_cnt = 0;
        t_sel = $realtime;
        t_edge = $realtime;
    end
    always @(posedge chain_clk) chain_cnt++;
    always @(flash_sck) if (flash_select_n === 1'b0) begin
        if (t_sck == 0.0) t_sck = $realtime;
        else if ($realtime - t_edge < min_phase) min_phase = $realtime - t_edge;
        t_edge = $realtime;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask : step

    task automatic test_done();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic wait_sel(input logic lvl);
        int n;
        n = 0;
        while (flash_select_n !== lvl && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        check("select_n", 32'(lvl), 32'(flash_select_n));
    endtask : wait_sel

    task automatic get_bytes(input logic [23:0] base, input int cnt);
        int n;
        logic [23:0] a;
        logic [7:0]  e;
        for (int i = 0; i < cnt; i++) begin
            n = 0;
            do begin
                @(negedge sys_clk);
                n++;
            end while (image_byte_valid !== 1'b1 && n < 400);
            a = base + 24'(i);
            e = a[7:0] ^ a[19:12] ^ 8'h5a;
            check("image_byte", 32'(e), 32'(image_byte));
            if (forward_wake) check("chain_data", 32'(e[0]), 32'(chain_data));
        end
    endtask : get_bytes

    task automatic jump_to(input logic [11:0] j);
        step();
        header_jump_addr = j;
        header_jump_valid = 1'b1;
        step();
        header_jump_valid = 1'b0;
    endtask : jump_to

    task automatic finish_load();
        logic in_range;
        step();
        step();
        load_done = 1'b1;
        step();
        load_done = 1'b0;
        wait_sel(1'b1);
        check("sck_parked", 32'h0, 32'(flash_sck));
        check("sck_phase", 32'h1, 32'(min_phase >= 7.5));
        in_range = (chain_cnt >= data_rises - 1) && (chain_cnt <= data_rises);
        if (forward_wake) check("chain", 32'h1, 32'(in_range));
        else check("chain_off", 32'h0, 32'(chain_cnt));
    endtask : finish_load

    task automatic restart_pulse();
        t_sck = 0.0;
        min_phase = 1.0e9;
        step();
        restart_n_pin = 1'b0;
        repeat (4) step();
        restart_n_pin = 1'b1;
    endtask : restart_pulse

    task automatic t_reset_state();
        check("select_n", 32'h1, 32'(flash_select_n));
        check("sck", 32'h0, 32'(flash_sck));
        check("active", 32'h0, 32'(load_active));
        restart_pulse();
        repeat (20) step();
        check("sel_falls", 32'h0, 32'(sel_falls));
    endtask : t_reset_state

    task automatic t_first_load();
        forward_wake = 1'b1;
        t_sck = 0.0;
        min_phase = 1.0e9;
        step();
        ready_pin = 1'b1;
        t0 = $realtime;
        wait_sel(1'b0);
        check("sel_time", 32'h1, 32'(t_sel - t0 >= 100.0 && t_sel - t0 <= 200.0));
        get_bytes(24'h000000, 2);
        check("sck_time", 32'h1, 32'(t_sck - t0 >= 2800.0 && t_sck - t0 <= 4400.0));
        check("cmd", 32'h03, 32'(cmd_seen));
        check("addr", 32'h0, 32'(addr_seen));
        jump_to(12'hab1);
        finish_load();
    endtask : t_first_load

    task automatic t_restart_jump(input logic [23:0] exp_addr, input logic [11:0] nxt);
        restart_pulse();
        wait_sel(1'b0);
        get_bytes(exp_addr, 2);
        check("jump_addr", 32'(exp_addr), 32'(addr_seen));
        jump_to(nxt);
        finish_load();
    endtask : t_restart_jump

    task automatic t_fast_read();
        ready_pin = 1'b0;
        quick_read_select_n = 1'b0;
        repeat (10) step();
        ready_pin = 1'b1;
        wait_sel(1'b0);
        repeat (140) step();
        check("cmd_fast", 32'h0b, 32'(cmd_seen));
        check("addr_fast", 32'h00fff000, 32'(addr_seen));
        get_bytes(24'hfff000, 2);
        finish_load();
        quick_read_select_n = 1'b1;
    endtask : t_fast_read

    task automatic t_refusals();
        int f;
        f = sel_falls;
        ready_pin = 1'b0;
        restart_is_gpio = 1'b1;
        repeat (10) step();
        ready_pin = 1'b1;
        repeat (20) step();
        restart_pulse();
        repeat (20) step();
        check("gpio_block", 32'(f), 32'(sel_falls));
        ready_pin = 1'b0;
        restart_is_gpio = 1'b0;
        master_serial_flash_mode = 1'b0;
        repeat (10) step();
        ready_pin = 1'b1;
        repeat (20) step();
        check("slave_idle", 32'(f), 32'(sel_falls));
        check("slave_active", 32'h0, 32'(load_active));
        master_serial_flash_mode = 1'b1;
    endtask : t_refusals

    task automatic t_power_cycle();
        t_sck = 0.0;
        min_phase = 1.0e9;
        reset_n = 1'b0;
        repeat (3) step();
        reset_n = 1'b1;
        wait_sel(1'b0);
        get_bytes(24'h000000, 1);
        check("addr_pwr", 32'h0, 32'(addr_seen));
        finish_load();
        restart_pulse();
        wait_sel(1'b0);
        get_bytes(24'h000000, 1);
        check("jump_rst", 32'h0, 32'(addr_seen));
        finish_load();
    endtask : t_power_cycle

    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        ready_pin = 1'b0;
        restart_n_pin = 1'b1;
        quick_read_select_n = 1'b1;
        master_serial_flash_mode = 1'b1;
        restart_is_gpio = 1'b0;
        forward_wake = 1'b0;
        header_jump_valid = 1'b0;
        header_jump_addr = 12'h000;
        load_done = 1'b0;
        errors = 0;
        checked = 0;
        sel_falls = 0;
        chain_cnt = 0;
        t_sck = 0.0;
        min_phase = 1.0e9;
        repeat (3) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        t_reset_state();
        t_first_load();
        forward_wake = 1'b0;
        t_restart_jump(24'hab1000, 12'h0ff);
        t_restart_jump(24'h0ff000, 12'hfff);
        t_fast_read();
        t_refusals();
        t_power_cycle();
        test_done();
    end

    initial begin
        #2000000;
        errors++;
        test_done();
    end
endmodule : sfbl_loader_tb_top
